// ==== imt_pkg.sv ====
// Shared constants and types for the indirect configuration and motion trigger registers
package imt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Direct register addresses
	localparam int          ADDR_W         = 6;
	localparam logic [5:0]  ADDR_RD_PTR    = 6'h17;
	localparam logic [5:0]  ADDR_SELECTOR  = 6'h18;
	localparam logic [5:0]  ADDR_UNLOCK    = 6'h1e;
	localparam logic [5:0]  ADDR_WINDOW    = 6'h22;

	////////////////////////////////////////////////////////////////////////
	// Indirect select codes
	localparam logic [4:0]  SEL_I2C_OFF    = 5'h01;
	localparam logic [4:0]  SEL_MOTION_CTL = 5'h02;
	localparam logic [4:0]  SEL_THRESH_Y   = 5'h03;
	localparam logic [4:0]  SEL_THRESH_X   = 5'h04;
	localparam logic [4:0]  SEL_THRESH_Z   = 5'h05;
	localparam logic [4:0]  SEL_OUT_CTL    = 5'h0b;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  RD_PTR_RST     = 8'h00;
	localparam logic [4:0]  SELECTOR_RST   = 5'h00;
	localparam logic [7:0]  MOTION_CTL_RST = 8'h07;
	localparam logic [7:0]  OUT_CTL_RST    = 8'h1c;
	localparam logic [7:0]  I2C_OFF_RST    = 8'h00;
	localparam logic [7:0]  THRESH_RST     = 8'h10;

	////////////////////////////////////////////////////////////////////////
	// Unlock key sequence and operating mode
	localparam logic [7:0]  KEY_FIRST      = 8'h00;
	localparam logic [7:0]  KEY_SECOND     = 8'h50;
	localparam logic [7:0]  KEY_THIRD      = 8'ha0;
	localparam logic [2:0]  MODE_MOTION    = 3'b011;

	// Magnitude bits actually used in each threshold code
	localparam int          MAG_BITS_XZ    = 6;
	localparam int          MAG_BITS_Y     = 7;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b001,
		KEY_GOT_A = 3'b010,
		KEY_GOT_B = 3'b100
	} imt_key_state_t;

	// Motion control layout: bits 5:3 require Z,X,Y; bits 2:0 enable Z,X,Y
	typedef struct packed {
		logic [1:0] rsvd;
		logic       req_z;
		logic       req_x;
		logic       req_y;
		logic       en_z;
		logic       en_x;
		logic       en_y;
	} imt_motion_ctl_t;

	// Triggered-axis report: bit 2 Y, bit 1 X, bit 0 Z
	typedef struct packed {
		logic y;
		logic x;
		logic z;
	} imt_axes_t;

endpackage

// ==== imt_axis_cmp.sv ====
// Per-axis threshold comparator for the motion detector
`timescale 1ns/1ps

module imt_axis_cmp #(
	parameter int MAG_BITS = 6
) (
	input  wire logic [7:0] thresh,
	input  wire logic [7:0] delta,
	output logic            hit
);

	generate
		if (MAG_BITS < 1 || MAG_BITS > 8) begin : g_bad_width
			$error("imt_axis_cmp: MAG_BITS must be 1 to 8");
		end
	endgenerate

	logic [7:0] used_mask;
	logic [7:0] thresh_used;

	// Unused upper code bits never weigh in on the comparison
	assign used_mask   = 8'(({8'h00, 8'hff} >> (8 - MAG_BITS)) & 16'h00ff);
	assign thresh_used = thresh & used_mask;

	// Raw unsigned codes, no correction; reaching the threshold counts as a hit
	assign hit = (delta >= thresh_used);

endmodule

// ==== imt_regs.sv ====
// Indirect configuration window, unlock key and motion trigger logic
//
// How it works
// - Write-only 8-bit I2C read pointer, resets to zero, only for I2C reads.
// - Selector holds 5-bit select field, resets zero, upper bits reserved.
// - Select codes: I2C off, motion control, Y, X, Z thresholds, output control.
// - Written selector maps its indirect register onto the data window.
// - Selector writes are ignored unless the configuration lock is open.
// - Motion control bits 5:3 require Z, X, Y; reset 0; AND condition.
// - Motion control bits 2:0 enable Z, X, Y; reset 1; OR condition.
// - Enable only X,Y fires on either; bits 7:6 reserved.
// - Each axis has its own 8-bit threshold for acceleration change.
// - Thresholds are unsigned magnitudes; reaching one raises the trigger.
// - Threshold reset value depends on variant, 10h or 08h.
// - X and Z ignore bits 7:6; Y ignores bit 7.
// - Raw threshold codes are compared with no correction.
// - Key sequence 00h, 50h, A0h opens lock; any other closes it.
// - Window write commits into selected indirect register, lock required.
// - Motion detector works only in motion detection mode 011.
// - Triggering axes reported as bit 2 Y, bit 1 X, bit 0 Z.
`timescale 1ns/1ps

module imt_regs #(
	parameter logic [7:0] THRESH_RESET = imt_pkg::THRESH_RST
) (
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [5:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic      [7:0]            reg_rdata,
	output logic      [7:0]            i2c_read_ptr,
	output logic                       lock_open,
	output logic      [7:0]            i2c_off_cfg,
	output logic      [7:0]            out_ctl_cfg,
	input  wire logic [2:0]            op_mode,
	input  wire logic                  sample_valid,
	input  wire logic [7:0]            delta_x,
	input  wire logic [7:0]            delta_y,
	input  wire logic [7:0]            delta_z,
	output logic                       motion_trig,
	output imt_pkg::imt_axes_t         motion_axes
);

	generate
		if (THRESH_RESET[7]) begin : g_bad_reset
			$error("imt_regs: THRESH_RESET uses an unused threshold bit");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0]                 rd_ptr_r;
	logic [4:0]                 sel_r;
	imt_pkg::imt_motion_ctl_t   mctl_r;
	logic [7:0]                 thr_x_r;
	logic [7:0]                 thr_y_r;
	logic [7:0]                 thr_z_r;
	logic [7:0]                 i2c_off_r;
	logic [7:0]                 out_ctl_r;
	logic                       lock_r;
	imt_pkg::imt_key_state_t    key_r;
	imt_pkg::imt_key_state_t    key_nxt;
	logic                       lock_nxt;
	logic [7:0]                 rdata_r;
	logic [7:0]                 rdata_nxt;
	logic                       trig_r;
	imt_pkg::imt_axes_t         axes_r;

	logic wr_ptr;
	logic wr_sel;
	logic wr_key;
	logic wr_win;
	logic sel_reserved;
	logic [7:0] win_value;

	assign wr_ptr = reg_wr && (reg_addr == imt_pkg::ADDR_RD_PTR);
	assign wr_sel = reg_wr && (reg_addr == imt_pkg::ADDR_SELECTOR);
	assign wr_key = reg_wr && (reg_addr == imt_pkg::ADDR_UNLOCK);
	assign wr_win = reg_wr && (reg_addr == imt_pkg::ADDR_WINDOW) && lock_r;

	////////////////////////////////////////////////////////////////////////
	// I2C read pointer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_ptr_r <= imt_pkg::RD_PTR_RST;
		end else if (wr_ptr) begin
			rd_ptr_r <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unlock key sequencer
	always_comb begin
		key_nxt  = imt_pkg::KEY_IDLE;
		lock_nxt = 1'b0;
		case (key_r)
			imt_pkg::KEY_IDLE: begin
				if (reg_wdata == imt_pkg::KEY_FIRST) begin
					key_nxt = imt_pkg::KEY_GOT_A;
				end
			end
			imt_pkg::KEY_GOT_A: begin
				if (reg_wdata == imt_pkg::KEY_SECOND) begin
					key_nxt = imt_pkg::KEY_GOT_B;
				end else if (reg_wdata == imt_pkg::KEY_FIRST) begin
					key_nxt = imt_pkg::KEY_GOT_A;
				end
			end
			imt_pkg::KEY_GOT_B: begin
				if (reg_wdata == imt_pkg::KEY_THIRD) begin
					lock_nxt = 1'b1;
				end else if (reg_wdata == imt_pkg::KEY_FIRST) begin
					key_nxt = imt_pkg::KEY_GOT_A;
				end
			end
			default: begin
				key_nxt = imt_pkg::KEY_IDLE;
			end
		endcase
	end

	// Every key write that does not finish the sequence closes the lock
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			key_r  <= imt_pkg::KEY_IDLE;
			lock_r <= 1'b0;
		end else if (wr_key) begin
			key_r  <= key_nxt;
			lock_r <= lock_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Selector
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sel_r <= imt_pkg::SELECTOR_RST;
		end else if (wr_sel && lock_r) begin
			sel_r <= reg_wdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indirect registers behind the window
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mctl_r    <= imt_pkg::MOTION_CTL_RST;
			thr_x_r   <= THRESH_RESET;
			thr_y_r   <= THRESH_RESET;
			thr_z_r   <= THRESH_RESET;
			i2c_off_r <= imt_pkg::I2C_OFF_RST;
			out_ctl_r <= imt_pkg::OUT_CTL_RST;
		end else if (wr_win) begin
			// Reserved codes fall through and store nothing
			case (sel_r)
				imt_pkg::SEL_I2C_OFF:    i2c_off_r <= reg_wdata;
				imt_pkg::SEL_MOTION_CTL: mctl_r    <= {2'b00, reg_wdata[5:0]};
				imt_pkg::SEL_THRESH_Y:   thr_y_r   <= reg_wdata;
				imt_pkg::SEL_THRESH_X:   thr_x_r   <= reg_wdata;
				imt_pkg::SEL_THRESH_Z:   thr_z_r   <= reg_wdata;
				imt_pkg::SEL_OUT_CTL:    out_ctl_r <= reg_wdata;
				default:                 out_ctl_r <= out_ctl_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path
	always_comb begin
		sel_reserved = 1'b0;
		case (sel_r)
			imt_pkg::SEL_I2C_OFF:    win_value = i2c_off_r;
			imt_pkg::SEL_MOTION_CTL: win_value = mctl_r;
			imt_pkg::SEL_THRESH_Y:   win_value = thr_y_r;
			imt_pkg::SEL_THRESH_X:   win_value = thr_x_r;
			imt_pkg::SEL_THRESH_Z:   win_value = thr_z_r;
			imt_pkg::SEL_OUT_CTL:    win_value = out_ctl_r;
			default: begin
				win_value    = 8'h00;
				sel_reserved = 1'b1;
			end
		endcase
	end

	// The pointer is write-only and the key register hides its contents
	always_comb begin
		case (reg_addr)
			imt_pkg::ADDR_SELECTOR: rdata_nxt = {3'b000, sel_r};
			imt_pkg::ADDR_WINDOW:   rdata_nxt = win_value;
			default:                rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Motion detector
	imt_pkg::imt_axes_t hit;
	imt_pkg::imt_axes_t hit_used;
	logic [2:0] req_zxy;
	logic [2:0] en_zxy;
	logic and_ok;
	logic or_ok;
	logic fire;

	imt_axis_cmp #(.MAG_BITS(imt_pkg::MAG_BITS_XZ)) u_cmp_x (
		.thresh (thr_x_r),
		.delta  (delta_x),
		.hit    (hit.x)
	);

	imt_axis_cmp #(.MAG_BITS(imt_pkg::MAG_BITS_Y)) u_cmp_y (
		.thresh (thr_y_r),
		.delta  (delta_y),
		.hit    (hit.y)
	);

	imt_axis_cmp #(.MAG_BITS(imt_pkg::MAG_BITS_XZ)) u_cmp_z (
		.thresh (thr_z_r),
		.delta  (delta_z),
		.hit    (hit.z)
	);

	assign req_zxy = {mctl_r.req_z, mctl_r.req_x, mctl_r.req_y};
	assign en_zxy  = {mctl_r.en_z, mctl_r.en_x, mctl_r.en_y};

	// Each required channel must trip, and at least one enabled one must too
	assign and_ok = (hit.z || !req_zxy[2]) && (hit.x || !req_zxy[1])
		&& (hit.y || !req_zxy[0]);
	assign or_ok  = (hit.z && en_zxy[2]) || (hit.x && en_zxy[1])
		|| (hit.y && en_zxy[0]);
	assign fire   = sample_valid && (op_mode == imt_pkg::MODE_MOTION)
		&& and_ok && or_ok;

	assign hit_used.y = hit.y && (en_zxy[0] || req_zxy[0]);
	assign hit_used.x = hit.x && (en_zxy[1] || req_zxy[1]);
	assign hit_used.z = hit.z && (en_zxy[2] || req_zxy[2]);

	// Settings are registers, so a window write lands before the next sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			trig_r <= 1'b0;
			axes_r <= 3'b000;
		end else begin
			trig_r <= fire;
			if (fire) begin
				axes_r <= hit_used;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata    = rdata_r;
	assign i2c_read_ptr = rd_ptr_r;
	assign lock_open    = lock_r;
	assign i2c_off_cfg  = i2c_off_r;
	assign out_ctl_cfg  = out_ctl_r;
	assign motion_trig  = trig_r;
	assign motion_axes  = axes_r;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_key_write(logic [7:0] v);
		reg_wr && reg_addr == imt_pkg::ADDR_UNLOCK && reg_wdata == v;
	endsequence

	// One idle bus cycle between key writes; other writes there must not touch the key
	sequence s_key_open;
		s_key_write(imt_pkg::KEY_FIRST) ##1 !wr_key ##1 s_key_write(imt_pkg::KEY_SECOND)
			##1 !wr_key ##1 s_key_write(imt_pkg::KEY_THIRD);
	endsequence

	a_unlock_sequence: assert property (s_key_open |=> lock_open)
		else $error("lock did not open after key sequence");

	a_key_bad_close: assert property (wr_key && reg_wdata != imt_pkg::KEY_THIRD
		|=> !lock_open)
		else $error("lock open after wrong key");

	a_sel_locked: assert property (wr_sel && !lock_open |=> $stable(sel_r))
		else $error("selector changed while locked");

	a_sel_take: assert property (wr_sel && lock_open
		|=> sel_r == $past(reg_wdata[4:0]))
		else $error("selector did not take write");

	a_ptr_take: assert property (wr_ptr |=> i2c_read_ptr == $past(reg_wdata))
		else $error("read pointer did not take write");

	a_thr_commit: assert property (wr_win && sel_r == imt_pkg::SEL_THRESH_X
		|=> thr_x_r == $past(reg_wdata))
		else $error("x threshold not committed");

	a_rsvd_read: assert property (reg_rd && reg_addr == imt_pkg::ADDR_WINDOW
		&& sel_reserved |=> reg_rdata == 8'h00)
		else $error("reserved window read not zero");

	a_and_trigger: assert property (sample_valid && mctl_r == 8'h1b
		&& !(hit.x && hit.y) |=> !motion_trig)
		else $error("and condition fired without x and y");

	a_or_trigger: assert property (sample_valid && op_mode == imt_pkg::MODE_MOTION
		&& mctl_r == 8'h03 && (hit.x || hit.y) |=> motion_trig ##0 motion_axes.z == 1'b0)
		else $error("or condition did not fire");

	a_mode_gate: assert property (op_mode != imt_pkg::MODE_MOTION |=> !motion_trig)
		else $error("trigger outside motion mode");

endmodule

// ==== imt_host_model.sv ====
// Host-side model: serial front end issuing single-byte register writes and reads
`timescale 1ns/1ps

module imt_host_model (
	input  wire logic       core_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [5:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 6'h00;
		reg_wdata = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Released address and data are inverted so a stale value never helps the device
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd   = 1'b0;
		reg_addr = ~a;
		d        = reg_rdata;
	endtask

	task automatic unlock();
		wr(imt_pkg::ADDR_UNLOCK, imt_pkg::KEY_FIRST);
		wr(imt_pkg::ADDR_UNLOCK, imt_pkg::KEY_SECOND);
		wr(imt_pkg::ADDR_UNLOCK, imt_pkg::KEY_THIRD);
	endtask

	// Always opens the lock first, so selector writes are never lost
	task automatic sel(input logic [4:0] code);
		unlock();
		wr(imt_pkg::ADDR_SELECTOR, {3'b000, code});
	endtask
endmodule

// ==== tb_imt_regs.sv ====
// Self-checking testbench for the indirect configuration and motion trigger registers
`timescale 1ns/1ps

module tb_imt_regs;
	logic               core_clk;
	logic               rstn;
	logic               reg_wr;
	logic               reg_rd;
	logic [5:0]         reg_addr;
	logic [7:0]         reg_wdata;
	logic [7:0]         reg_rdata;
	logic [7:0]         i2c_read_ptr;
	logic               lock_open;
	logic [7:0]         i2c_off_cfg;
	logic [7:0]         out_ctl_cfg;
	logic [2:0]         op_mode;
	logic               sample_valid;
	logic [7:0]         delta_x;
	logic [7:0]         delta_y;
	logic [7:0]         delta_z;
	logic               motion_trig;
	imt_pkg::imt_axes_t motion_axes;
	int                 fail_count = 0;
	int                 n_tests = 0;
	int                 cycles = 0;
	logic [31:0]        rng;
	logic [7:0]         thr [3];
	logic [7:0]         mctl;
	logic [2:0]         axes_exp;

	imt_host_model i_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	imt_regs i_dut (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.i2c_read_ptr(i2c_read_ptr), .lock_open(lock_open), .i2c_off_cfg(i2c_off_cfg),
		.out_ctl_cfg(out_ctl_cfg), .op_mode(op_mode), .sample_valid(sample_valid),
		.delta_x(delta_x), .delta_y(delta_y), .delta_z(delta_z),
		.motion_trig(motion_trig), .motion_axes(motion_axes));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction

	// Result is {fire, axes as y,x,z}; only the used magnitude bits of each threshold count
	function automatic logic [3:0] motion_exp(input logic [7:0] c, input logic [7:0] dx,
		input logic [7:0] dy, input logic [7:0] dz);
		logic [2:0] hit;
		logic [2:0] req;
		logic [2:0] en;
		hit = {dy >= (thr[1] & 8'h7f), dx >= (thr[0] & 8'h3f), dz >= (thr[2] & 8'h3f)};
		req = {c[3], c[4], c[5]};
		en  = {c[0], c[1], c[2]};
		return {((hit & req) == req) && ((hit & en) != 3'b000), hit & (en | req)};
	endfunction

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(what, d, exp);
	endtask

	task automatic sample(input logic [2:0] m, input logic [7:0] dx, input logic [7:0] dy,
		input logic [7:0] dz);
		logic [3:0] e;
		e = motion_exp(mctl, dx, dy, dz);
		@(posedge core_clk);
		#1;
		op_mode      = m;
		sample_valid = 1'b1;
		delta_x      = dx;
		delta_y      = dy;
		delta_z      = dz;
		@(posedge core_clk);
		#1;
		sample_valid = 1'b0;
		delta_x      = ~dx;
		if (m != imt_pkg::MODE_MOTION) e[3] = 1'b0;
		if (e[3]) axes_exp = e[2:0];
		chk("motion_trig", {7'h00, motion_trig}, {7'h00, e[3]});
		chk("motion_axes", {5'h00, motion_axes}, {5'h00, axes_exp});
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [4:0] codes [6];
		logic [7:0] rstv [6];
		logic [7:0] kept [6];
		logic [7:0] ctls [4];
		logic [7:0] v;
		rstn = 1'b0;
		op_mode = 3'b000;
		sample_valid = 1'b0;
		delta_x = 8'h00;
		delta_y = 8'h00;
		delta_z = 8'h00;
		rng = 32'h0000fbd9;
		axes_exp = 3'b000;
		codes = '{imt_pkg::SEL_I2C_OFF, imt_pkg::SEL_MOTION_CTL, imt_pkg::SEL_THRESH_Y,
			imt_pkg::SEL_THRESH_X, imt_pkg::SEL_THRESH_Z, imt_pkg::SEL_OUT_CTL};
		rstv = '{8'h00, 8'h07, 8'h10, 8'h10, 8'h10, 8'h1c};
		repeat (6) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		chk("lock_open", {7'h00, lock_open}, 8'h00);
		chk("i2c_read_ptr", i2c_read_ptr, 8'h00);
		chk("out_ctl_cfg", out_ctl_cfg, 8'h1c);
		rdchk(imt_pkg::ADDR_SELECTOR, 8'h00, "selector");
		rdchk(imt_pkg::ADDR_WINDOW, 8'h00, "window");
		$display("test reset done");
		// Selector write with the lock closed must be dropped
		i_host.wr(imt_pkg::ADDR_SELECTOR, 8'h04);
		rdchk(imt_pkg::ADDR_SELECTOR, 8'h00, "selector");
		i_host.unlock();
		chk("lock_open", {7'h00, lock_open}, 8'h01);
		i_host.wr(imt_pkg::ADDR_SELECTOR, 8'he9);
		rdchk(imt_pkg::ADDR_SELECTOR, 8'h09, "selector");
		i_host.wr(imt_pkg::ADDR_WINDOW, 8'h5a);
		rdchk(imt_pkg::ADDR_WINDOW, 8'h00, "window");
		$display("test lock done");
		for (int i = 0; i < 6; i++) begin
			i_host.sel(codes[i]);
			rdchk(imt_pkg::ADDR_WINDOW, rstv[i], "indirect reset");
			v = rnd();
			kept[i] = (i == 1) ? (v & 8'h3f) : v;
			i_host.wr(imt_pkg::ADDR_WINDOW, v);
			rdchk(imt_pkg::ADDR_WINDOW, kept[i], "indirect");
		end
		chk("i2c_off_cfg", i2c_off_cfg, kept[0]);
		chk("out_ctl_cfg", out_ctl_cfg, kept[5]);
		$display("test indirect done");
		i_host.wr(imt_pkg::ADDR_UNLOCK, 8'h33);
		chk("lock_open", {7'h00, lock_open}, 8'h00);
		i_host.wr(imt_pkg::ADDR_WINDOW, ~kept[5]);
		chk("out_ctl_cfg", out_ctl_cfg, kept[5]);
		v = rnd();
		i_host.wr(imt_pkg::ADDR_RD_PTR, v);
		chk("i2c_read_ptr", i2c_read_ptr, v);
		rdchk(imt_pkg::ADDR_RD_PTR, 8'h00, "read pointer");
		rdchk(6'h3f, 8'h00, "unmapped");
		$display("test closed done");
		thr = '{kept[3], kept[2], kept[4]};
		i_host.sel(imt_pkg::SEL_THRESH_X);
		i_host.wr(imt_pkg::ADDR_WINDOW, 8'hc5);
		thr[0] = 8'hc5;
		ctls = '{8'h1b, 8'h03, 8'h38, rnd()};
		for (int k = 0; k < 4; k++) begin
			i_host.sel(imt_pkg::SEL_MOTION_CTL);
			i_host.wr(imt_pkg::ADDR_WINDOW, ctls[k]);
			mctl = ctls[k] & 8'h3f;
			// Exactly at threshold, then outside motion mode, then random
			sample(imt_pkg::MODE_MOTION, thr[0] & 8'h3f, thr[1] & 8'h7f, thr[2] & 8'h3f);
			sample(3'b000, thr[0] & 8'h3f, thr[1] & 8'h7f, thr[2] & 8'h3f);
			for (int j = 0; j < 10; j++) begin
				v = rnd();
				sample(v[7] ? imt_pkg::MODE_MOTION : v[2:0], rnd() & 8'h3f, rnd() & 8'h7f,
					rnd() & 8'h3f);
			end
		end
		$display("test motion done");
		end_of_test();
	end
endmodule
